// ### core/swc_controller.sv
// power-down sequencer: sleep entry, wake-up sources, register file
//
// Added by the designer: the Wishbone register port and the placing of the registers.
`timescale 1ns/10ps

module swc_controller
   import swc_pkg::*;
#(
   parameter logic [WDT_BASE_W-1:0] WDT_BASE = WDT_BASE_CYCLES
) (
   input  logic                  clk,
   input  logic                  rst,
   input  logic                  wb_cyc,
   input  logic                  wb_stb,
   input  logic                  wb_we,
   input  logic [WB_AW-1:0]      wb_adr,
   input  logic [WB_SW-1:0]      wb_sel,
   input  logic [WB_DW-1:0]      wb_dat_wr,
   output logic [WB_DW-1:0]      wb_dat_rd,
   output logic                  wb_ack,
   input  logic                  sleep_instr,
   input  logic                  watchdog_clear_instruction,
   input  logic                  global_irq_enable,
   input  logic                  master_clear_pin_n,
   input  swc_src_t              irq_flags,
   input  logic                  phase_irq_flag,
   input  swc_pins_t             pins_core,
   output swc_pins_t             pins_hold_r,
   output logic                  osc_drive_en_r,
   output logic                  phase_clk_en_r,
   output logic                  device_reset_r,
   output logic                  resume_r,
   output logic                  prefetch_r,
   output logic                  sleep_nop_r,
   output logic                  vector_req_r,
   output logic [VEC_W-1:0]      vector_addr_r,
   output logic                  power_down_flag_r,
   output logic                  timeout_flag_r
);

   // ***************************************************************
   // declarations
   // ***************************************************************
   swc_state_t       state_r, state_nxt;
   swc_cause_t       cause_r, cause_nxt;
   swc_ctrl_t        ctrl_r, ctrl_nxt;
   swc_pins_t        pins_nxt;
   logic [IEN_W-1:0] ien_r, ien_nxt;
   logic [WB_DW-1:0] rd_nxt;
   logic             ack_nxt;
   logic             pd_nxt;
   logic             to_nxt;
   logic             dev_rst_nxt;
   logic             resume_nxt;
   logic             prefetch_nxt;
   logic             nop_nxt;
   logic             vec_nxt;
   logic             osc_nxt;
   logic             phase_nxt;
   logic             pend_wake;
   logic             pend_any;
   logic             wdt_clear;
   logic             wdt_timeout;
   logic             ost_start;
   logic             ost_done;

   // ***************************************************************
   // register bus slave
   // ***************************************************************
   // one-cycle answer; unmapped words read zero and ignore writes
   always_comb begin
      ack_nxt  = wb_cyc & wb_stb & ~wb_ack;
      rd_nxt   = '0;
      ctrl_nxt = ctrl_r;
      ien_nxt  = ien_r;
      if (ack_nxt) begin
         unique case (wb_adr)
            REG_STATUS: begin
               rd_nxt[ST_PD_BIT] = power_down_flag_r;
               rd_nxt[ST_TO_BIT] = timeout_flag_r;
            end
            REG_CTRL: begin
               rd_nxt[CTRL_W-1:0] = ctrl_r;
               if (wb_we && wb_sel[0]) begin
                  ctrl_nxt = swc_ctrl_t'(wb_dat_wr[CTRL_W-1:0]);
               end
            end
            REG_IEN: begin
               rd_nxt[IEN_W-1:0] = ien_r;
               if (wb_we && wb_sel[0]) begin
                  ien_nxt[NSRC-1:0] = wb_dat_wr[NSRC-1:0];
               end
               if (wb_we && wb_sel[1]) begin
                  ien_nxt[IEN_PHASE_BIT] = wb_dat_wr[IEN_PHASE_BIT];
               end
            end
            REG_INFO: begin
               rd_nxt[INFO_STATE_LSB +: $bits(state_r)] = state_r;
               rd_nxt[INFO_CAUSE_LSB +: $bits(cause_r)] = cause_r;
            end
            default: begin
               rd_nxt = '0;
            end
         endcase
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wb_ack    <= 1'b0;
         wb_dat_rd <= '0;
         ctrl_r    <= swc_ctrl_t'(CTRL_RESET);
         ien_r     <= IEN_RESET;
      end else begin
         wb_ack    <= ack_nxt;
         wb_dat_rd <= rd_nxt;
         ctrl_r    <= ctrl_nxt;
         ien_r     <= ien_nxt;
      end
   end

   // ***************************************************************
   // wake request
   // ***************************************************************
   // only clockless peripherals have a place in irq_flags
   assign pend_wake = |(irq_flags & ien_r[NSRC-1:0]);
   // phase-clocked flags may cancel a sleep but never wake one
   assign pend_any  = pend_wake | (phase_irq_flag & ien_r[IEN_PHASE_BIT]);

   // ***************************************************************
   // watchdog and start-up timer
   // ***************************************************************
   // prescaler assignment lives in ctrl_r and is not touched here
   assign wdt_clear = (state_r == ST_ENTER)
                      | watchdog_clear_instruction;

   swc_watchdog #(
      .BASE    (WDT_BASE)
   ) u_wdt (
      .clk     (clk),
      .rst     (rst),
      .run     (ctrl_r.wdt_en),
      .clear   (wdt_clear),
      .psa     (ctrl_r.psa),
      .ps      (ctrl_r.ps),
      .timeout (wdt_timeout)
   );

   swc_ost u_ost (
      .clk   (clk),
      .rst   (rst),
      .start (ost_start),
      .done  (ost_done)
   );

   // ***************************************************************
   // sleep sequencer
   // ***************************************************************
   always_comb begin
      state_nxt    = state_r;
      cause_nxt    = cause_r;
      pd_nxt       = power_down_flag_r;
      to_nxt       = timeout_flag_r;
      dev_rst_nxt  = 1'b0;
      resume_nxt   = 1'b0;
      prefetch_nxt = 1'b0;
      nop_nxt      = 1'b0;
      vec_nxt      = 1'b0;
      ost_start    = 1'b0;
      if (!master_clear_pin_n) begin
         // held reset level; flags are left for software to inspect
         dev_rst_nxt = 1'b1;
         state_nxt   = ST_AWAKE;
         if (state_r != ST_AWAKE) begin
            cause_nxt = CAUSE_MASTER_CLEAR_PIN;
         end
      end else begin
         unique case (state_r)
            ST_AWAKE: begin
               if (wdt_timeout) begin
                  dev_rst_nxt = 1'b1;
                  to_nxt      = 1'b0;
               end else if (sleep_instr) begin
                  prefetch_nxt = 1'b1;
                  if (pend_any) begin
                     nop_nxt = 1'b1;
                  end else begin
                     state_nxt = ST_ENTER;
                  end
               end
            end
            ST_ENTER: begin
               // entry always completes, a late flag wakes next cycle
               pd_nxt    = 1'b0;
               to_nxt    = 1'b1;
               state_nxt = ST_SLEEP;
            end
            ST_SLEEP: begin
               if (wdt_timeout) begin
                  to_nxt    = 1'b0;
                  cause_nxt = CAUSE_WDT;
               end else if (pend_wake) begin
                  cause_nxt = CAUSE_IRQ;
               end
               if (wdt_timeout || pend_wake) begin
                  if (ctrl_r.rc_osc) begin
                     // rc oscillator needs no start-up wait
                     state_nxt  = ST_AWAKE;
                     resume_nxt = 1'b1;
                     vec_nxt    = !wdt_timeout && global_irq_enable;
                  end else begin
                     state_nxt = ST_START;
                     ost_start = 1'b1;
                  end
               end
            end
            ST_START: begin
               if (ost_done) begin
                  state_nxt  = ST_AWAKE;
                  resume_nxt = 1'b1;
                  vec_nxt    = (cause_r == CAUSE_IRQ)
                               && global_irq_enable;
               end
            end
         endcase
      end
   end

   // ***************************************************************
   // clock gating and pin hold
   // ***************************************************************
   always_comb begin
      // driver stays off until the start-up wait begins, or until resume when rc_osc is set
      osc_nxt   = !((state_nxt == ST_ENTER)
                    || (state_nxt == ST_SLEEP));
      // phase clocks only while the core runs
      phase_nxt = (state_nxt == ST_AWAKE);
      if (state_nxt == ST_AWAKE) begin
         pins_nxt = pins_core;
      end else begin
         pins_nxt = pins_hold_r;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_r           <= ST_AWAKE;
         cause_r           <= CAUSE_NONE;
         power_down_flag_r <= 1'b1;
         timeout_flag_r    <= 1'b1;
         device_reset_r    <= 1'b0;
         resume_r          <= 1'b0;
         prefetch_r        <= 1'b0;
         sleep_nop_r       <= 1'b0;
         vector_req_r      <= 1'b0;
         vector_addr_r     <= VECTOR_ADDR;
         osc_drive_en_r    <= 1'b1;
         phase_clk_en_r    <= 1'b1;
         pins_hold_r       <= '0;
      end else begin
         state_r           <= state_nxt;
         cause_r           <= cause_nxt;
         power_down_flag_r <= pd_nxt;
         timeout_flag_r    <= to_nxt;
         device_reset_r    <= dev_rst_nxt;
         resume_r          <= resume_nxt;
         prefetch_r        <= prefetch_nxt;
         sleep_nop_r       <= nop_nxt;
         vector_req_r      <= vec_nxt;
         vector_addr_r     <= VECTOR_ADDR;
         osc_drive_en_r    <= osc_nxt;
         phase_clk_en_r    <= phase_nxt;
         pins_hold_r       <= pins_nxt;
      end
   end

endmodule

// ### core/swc_pkg.sv
// shared constants and types of the sleep/wake-up controller
package swc_pkg;

   // ***************************************************************
   // timing
   // ***************************************************************
   localparam int unsigned CLK_PERIOD_NS = 20;
   localparam int unsigned TOSC_NS       = 20;
   localparam int unsigned OST_TOSC      = 1024;
   localparam int unsigned OST_CYCLES    =
      (OST_TOSC * TOSC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned OST_W         = 11;
   localparam int unsigned WDT_PERIOD_NS = 18_000_000;
   localparam int unsigned WDT_BASE_W    = 20;
   localparam logic [WDT_BASE_W-1:0] WDT_BASE_CYCLES =
      WDT_BASE_W'(WDT_PERIOD_NS / CLK_PERIOD_NS);
   localparam int unsigned WDT_POST_W    = 7;
   localparam int unsigned WDT_PS_W      = 3;

   // ***************************************************************
   // register map and fields
   // ***************************************************************
   localparam int unsigned WB_AW          = 5;
   localparam int unsigned WB_DW          = 32;
   localparam int unsigned WB_SW          = 4;
   localparam logic [WB_AW-1:0] REG_STATUS = 5'h00;
   localparam logic [WB_AW-1:0] REG_CTRL   = 5'h04;
   localparam logic [WB_AW-1:0] REG_IEN    = 5'h08;
   localparam logic [WB_AW-1:0] REG_INFO   = 5'h0c;
   localparam int unsigned ST_PD_BIT      = 3;
   localparam int unsigned ST_TO_BIT      = 4;
   localparam int unsigned INFO_STATE_LSB = 0;
   localparam int unsigned INFO_CAUSE_LSB = 2;
   localparam int unsigned NSRC           = 8;
   localparam int unsigned IEN_PHASE_BIT  = NSRC;
   localparam int unsigned IEN_W          = NSRC + 1;
   localparam int unsigned CTRL_W         = 6;
   localparam logic [CTRL_W-1:0] CTRL_RESET = 6'h01;
   localparam logic [IEN_W-1:0]  IEN_RESET  = 9'h000;
   localparam int unsigned IO_W           = 8;
   localparam int unsigned VEC_W          = 13;
   localparam logic [VEC_W-1:0] VECTOR_ADDR = 13'h0004;

   // ***************************************************************
   // types
   // ***************************************************************
   typedef enum logic [1:0] {
      ST_AWAKE = 2'h0,
      ST_ENTER = 2'h1,
      ST_SLEEP = 2'h3,
      ST_START = 2'h2
   } swc_state_t;

   typedef enum logic [1:0] {
      CAUSE_NONE = 2'h0,
      CAUSE_WDT  = 2'h1,
      CAUSE_IRQ  = 2'h2,
      CAUSE_MASTER_CLEAR_PIN = 2'h3
   } swc_cause_t;

   // wake-capable sources, bit 0 is edge_irq
   typedef struct packed {
      logic usart_sync;
      logic psp_access;
      logic capture;
      logic ssp_xfer;
      logic ssp_startstop;
      logic timer_one;
      logic port_change;
      logic edge_irq;
   } swc_src_t;

   typedef struct packed {
      logic [WDT_PS_W-1:0] ps;
      logic                psa;
      logic                rc_osc;
      logic                wdt_en;
   } swc_ctrl_t;

   typedef struct packed {
      logic [IO_W-1:0] out;
      logic [IO_W-1:0] oe;
   } swc_pins_t;

endpackage

// ### core/swc_watchdog.sv
// watchdog counter with optional postscaler
`timescale 1ns/10ps
module swc_watchdog
   import swc_pkg::*;
#(
   parameter logic [WDT_BASE_W-1:0] BASE = WDT_BASE_CYCLES
) (
   input  logic                clk,
   input  logic                rst,
   input  logic                run,
   input  logic                clear,
   input  logic                psa,
   input  logic [WDT_PS_W-1:0] ps,
   output logic                timeout
);

   logic [WDT_BASE_W-1:0] base_r, base_nxt;
   logic [WDT_POST_W-1:0] post_r, post_nxt, post_max;
   logic                  to_nxt;

   // postscaler ratio 1:2^ps, only when assigned here
   assign post_max = psa ? WDT_POST_W'((1 << ps) - 1) : '0;

   always_comb begin
      base_nxt = base_r;
      post_nxt = post_r;
      to_nxt   = 1'b0;
      if (clear || !run) begin
         // the assignment bit itself is left alone
         base_nxt = '0;
         post_nxt = '0;
      end else if (base_r == BASE - 1'b1) begin
         base_nxt = '0;
         if (post_r >= post_max) begin
            post_nxt = '0;
            to_nxt   = 1'b1;
         end else begin
            post_nxt = post_r + 1'b1;
         end
      end else begin
         base_nxt = base_r + 1'b1;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         base_r  <= '0;
         post_r  <= '0;
         timeout <= 1'b0;
      end else begin
         base_r  <= base_nxt;
         post_r  <= post_nxt;
         timeout <= to_nxt;
      end
   end

endmodule

// ### core/swc_ost.sv
// oscillator start-up timer
`timescale 1ns/10ps
module swc_ost
   import swc_pkg::*;
(
   input  logic clk,
   input  logic rst,
   input  logic start,
   output logic done
);

   logic [OST_W-1:0] cnt_r, cnt_nxt;
   logic             busy_r, busy_nxt, done_nxt;

   always_comb begin
      cnt_nxt  = cnt_r;
      busy_nxt = busy_r;
      done_nxt = 1'b0;
      if (start) begin
         cnt_nxt  = '0;
         busy_nxt = 1'b1;
      end else if (busy_r) begin
         if (cnt_r == OST_W'(OST_CYCLES - 1)) begin
            busy_nxt = 1'b0;
            done_nxt = 1'b1;
         end else begin
            cnt_nxt = cnt_r + 1'b1;
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt_r  <= '0;
         busy_r <= 1'b0;
         done   <= 1'b0;
      end else begin
         cnt_r  <= cnt_nxt;
         busy_r <= busy_nxt;
         done   <= done_nxt;
      end
   end

endmodule

// ### sim/swc_checker.sv
// concurrent checks of the sleep/wake-up controller ports
`timescale 1ns/10ps
module swc_checker
   import swc_pkg::*;
(
   input logic             clk,
   input logic             rst,
   input logic             sleep_instr,
   input logic             master_clear_pin_n,
   input swc_pins_t        pins_hold_r,
   input logic             osc_drive_en_r,
   input logic             phase_clk_en_r,
   input logic             device_reset_r,
   input logic             resume_r,
   input logic             prefetch_r,
   input logic             sleep_nop_r,
   input logic             vector_req_r,
   input logic [VEC_W-1:0] vector_addr_r,
   input logic             power_down_flag_r,
   input logic             timeout_flag_r
);
   // ***************************************************************
   // start-up wait counter
   // ***************************************************************
   localparam int OST_MAX = 1100;
   logic [11:0] ost_cnt_r;
   logic [11:0] ost_cnt_nxt;

   // counts cycles with oscillator on but phase clocks still held
   always_comb begin
      ost_cnt_nxt = ost_cnt_r + 12'h001;
      if (phase_clk_en_r || !osc_drive_en_r) begin
         ost_cnt_nxt = 12'h000;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ost_cnt_r <= 12'h000;
      end else begin
         ost_cnt_r <= ost_cnt_nxt;
      end
   end

   // ***************************************************************
   // properties
   // ***************************************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   sequence s_taken;
      sleep_instr && phase_clk_en_r && master_clear_pin_n;
   endsequence
   sequence s_entered;
      prefetch_r && !sleep_nop_r;
   endsequence

   AST_PREFETCH: assert property (s_taken |=> prefetch_r)
      else $error("no prefetch after power-down instruction");
   AST_OSC_OFF: assert property (s_taken ##1 s_entered |->
      !osc_drive_en_r && !phase_clk_en_r)
      else $error("oscillator still on after entry");
   AST_FLAGS: assert property (s_taken ##1 s_entered |=>
      !power_down_flag_r && timeout_flag_r)
      else $error("status flags wrong after entry");
   AST_NOP: assert property (sleep_nop_r |-> osc_drive_en_r ##1
      $stable(power_down_flag_r) && $stable(timeout_flag_r))
      else $error("no-op entry changed state");
   AST_ONLY_INSTR: assert property ($fell(phase_clk_en_r) |->
      $past(sleep_instr))
      else $error("phase clocks stopped without instruction");
   AST_PINS_HOLD: assert property (!phase_clk_en_r &&
      $past(phase_clk_en_r) == 1'b0 |-> $stable(pins_hold_r))
      else $error("pins moved while powered down");
   AST_MASTER_CLEAR_PIN: assert property (!master_clear_pin_n |=>
      device_reset_r && !resume_r)
      else $error("master clear gave no reset");
   AST_VECTOR: assert property (vector_req_r |->
      resume_r && vector_addr_r == VECTOR_ADDR)
      else $error("vector request unpaired or wrong address");
   AST_RESUME: assert property (resume_r |->
      $past(phase_clk_en_r) == 1'b0)
      else $error("resume without a power-down");
   AST_OST_MIN: assert property (resume_r && ost_cnt_r > 12'h004 |->
      ost_cnt_r >= 12'(OST_TOSC))
      else $error("start-up wait too short");
   AST_OST_MAX: assert property (ost_cnt_r <= OST_MAX)
      else $error("start-up wait too long");
endmodule

bind swc_controller swc_checker u_chk (
   .clk, .rst, .sleep_instr, .master_clear_pin_n, .pins_hold_r,
   .osc_drive_en_r, .phase_clk_en_r, .device_reset_r, .resume_r,
   .prefetch_r, .sleep_nop_r, .vector_req_r, .vector_addr_r,
   .power_down_flag_r, .timeout_flag_r
);

// ### sim/swc_core_model.sv
// partner model: core sequencer and level interrupt sources
`timescale 1ns/10ps
module swc_core_model
   import swc_pkg::*;
(
   input  logic      clk,
   input  logic      rst,
   input  logic      cmd_sleep,
   input  swc_src_t  set_flags,
   input  logic      set_phase,
   input  logic      clr_all,
   output logic      sleep_instr,
   output logic      watchdog_clear_instruction,
   output swc_src_t  irq_flags,
   output logic      phase_irq_flag,
   output swc_pins_t pins_core
);
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sleep_instr <= 1'b0;
         watchdog_clear_instruction <= 1'b0;
         irq_flags <= '0;
         phase_irq_flag <= 1'b0;
         pins_core <= '0;
      end else begin
         // watchdog cleared just before the power-down instruction
         watchdog_clear_instruction <= cmd_sleep;
         // slot after the instruction stays empty, like a no-op
         sleep_instr <= watchdog_clear_instruction;
         // flags stay set until software clears them
         irq_flags <= clr_all ? '0 : (irq_flags | set_flags);
         phase_irq_flag <= !clr_all && (phase_irq_flag || set_phase);
         // port logic keeps toggling so a frozen hold is visible
         pins_core <= pins_core + 16'h0001;
      end
   end
endmodule

// ### sim/swc_controller_bench.sv
// self-checking bench of the sleep/wake-up controller
`timescale 1ns/10ps
module swc_controller_bench
   import swc_pkg::*;
;
   logic             clk, rst, wb_cyc, wb_stb, wb_we, wb_ack;
   logic [WB_AW-1:0] wb_adr;
   logic [WB_SW-1:0] wb_sel;
   logic [WB_DW-1:0] wb_dat_wr, wb_dat_rd, rd;
   logic             sleep_instr, watchdog_clear_instruction;
   logic             global_irq_enable, master_clear_pin_n;
   logic             phase_irq_flag, cmd_sleep, set_phase, clr_all;
   swc_src_t         irq_flags, set_flags;
   swc_pins_t        pins_core, pins_hold_r, pins_snap;
   logic             osc_drive_en_r, phase_clk_en_r, device_reset_r;
   logic             resume_r, prefetch_r, sleep_nop_r, vector_req_r;
   logic [VEC_W-1:0] vector_addr_r;
   logic             power_down_flag_r, timeout_flag_r;
   int               mismatches = 0, n_compared = 0, cycles = 0, n;

   swc_controller #(.WDT_BASE(20'h00040)) i_dut (
      .clk, .rst, .wb_cyc, .wb_stb, .wb_we, .wb_adr, .wb_sel,
      .wb_dat_wr, .wb_dat_rd, .wb_ack, .sleep_instr,
      .watchdog_clear_instruction, .global_irq_enable,
      .master_clear_pin_n, .irq_flags, .phase_irq_flag, .pins_core,
      .pins_hold_r, .osc_drive_en_r, .phase_clk_en_r, .device_reset_r,
      .resume_r, .prefetch_r, .sleep_nop_r, .vector_req_r,
      .vector_addr_r, .power_down_flag_r, .timeout_flag_r);

   swc_core_model i_core (
      .clk, .rst, .cmd_sleep, .set_flags, .set_phase, .clr_all,
      .sleep_instr, .watchdog_clear_instruction, .irq_flags,
      .phase_irq_flag, .pins_core);

   // ***************************************************************
   // clock, watchdog on the run, shared tasks
   // ***************************************************************
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 6000) begin
         mismatches++;
         summarize();
      end
   end

   task automatic summarize;
      if (mismatches == 0 && n_compared > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask

   task automatic wb(input logic [WB_AW-1:0] a, input logic w,
                     input logic [WB_DW-1:0] d);
      @(posedge clk);
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we <= w;
      wb_adr <= a;
      wb_dat_wr <= d;
      @(posedge clk iff wb_ack);
      rd = wb_dat_rd;
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
   endtask

   task automatic pulse(input swc_src_t f, input logic p, input logic c);
      @(posedge clk);
      set_flags <= f;
      set_phase <= p;
      clr_all <= c;
      @(posedge clk);
      set_flags <= '0;
      set_phase <= 1'b0;
      clr_all <= 1'b0;
   endtask

   task automatic go_sleep;
      @(posedge clk);
      cmd_sleep <= 1'b1;
      @(posedge clk);
      cmd_sleep <= 1'b0;
      @(posedge clk iff prefetch_r);
   endtask

   task automatic wait_resume;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (resume_r !== 1'b1);
   endtask

   // ***************************************************************
   // scenarios
   // ***************************************************************
   task automatic t_regs;
      wb(REG_STATUS, 1'b0, '0);
      chk(rd, 32'h0000_0018);
      wb(REG_CTRL, 1'b1, 32'h0000_0000);
      wb(5'h10, 1'b1, 32'hffff_ffff);
      wb(5'h10, 1'b0, '0);
      chk(rd, 32'h0000_0000);
      chk(32'(vector_addr_r), 32'h0000_0004);
   endtask

   task automatic t_nop;
      wb(REG_IEN, 1'b1, 32'h0000_0001);
      pulse(8'h01, 1'b0, 1'b0);
      go_sleep();
      chk(32'(sleep_nop_r), 32'h1);
      wb(REG_STATUS, 1'b0, '0);
      chk(rd, 32'h0000_0018);
      pulse(8'h00, 1'b0, 1'b1);
   endtask

   task automatic t_irq;
      global_irq_enable <= 1'b1;
      wb(REG_IEN, 1'b1, 32'h0000_0101);
      go_sleep();
      chk(32'({sleep_nop_r, osc_drive_en_r}), 32'h0);
      repeat (2) @(posedge clk);
      pins_snap = pins_hold_r;
      wb(REG_STATUS, 1'b0, '0);
      chk(rd, 32'h0000_0010);
      // phase-clocked and disabled sources must not wake
      pulse(8'h02, 1'b1, 1'b0);
      repeat (30) @(posedge clk);
      chk(32'(phase_clk_en_r), 32'h0);
      chk(32'(pins_hold_r), 32'(pins_snap));
      pulse(8'h00, 1'b0, 1'b1);
      pulse(8'h01, 1'b0, 1'b0);
      wait_resume();
      chk(32'(vector_req_r), 32'h1);
      chk(32'(n >= OST_TOSC && n < OST_TOSC + 16), 32'h1);
      wb(REG_INFO, 1'b0, '0);
      chk(rd, 32'h0000_0008);
      pulse(8'h00, 1'b0, 1'b1);
      global_irq_enable <= 1'b0;
   endtask

   task automatic t_wdt;
      wb(REG_IEN, 1'b1, 32'h0000_0000);
      wb(REG_CTRL, 1'b1, 32'h0000_0003);
      go_sleep();
      wait_resume();
      chk(32'(vector_req_r), 32'h0);
      chk(32'(n > 55 && n < 75), 32'h1);
      wb(REG_STATUS, 1'b0, '0);
      chk(rd, 32'h0000_0000);
      wb(REG_INFO, 1'b0, '0);
      chk(rd, 32'h0000_0004);
      @(posedge clk iff device_reset_r);
      chk(32'(phase_clk_en_r), 32'h1);
      wb(REG_CTRL, 1'b1, 32'h0000_0000);
   endtask

   task automatic t_master_clear_pin;
      go_sleep();
      repeat (4) @(posedge clk);
      master_clear_pin_n <= 1'b0;
      repeat (2) @(posedge clk);
      chk(32'(device_reset_r), 32'h1);
      master_clear_pin_n <= 1'b1;
      n = 0;
      repeat (1100) @(posedge clk) if (resume_r) n++;
      chk(32'(n), 32'h0);
      wb(REG_STATUS, 1'b0, '0);
      chk(rd, 32'h0000_0010);
   endtask

   initial begin
      rst = 1'b1;
      {wb_cyc, wb_stb, wb_we, cmd_sleep, set_phase, clr_all} = '0;
      wb_adr = '0;
      wb_sel = 4'hf;
      wb_dat_wr = '0;
      set_flags = '0;
      global_irq_enable = 1'b0;
      master_clear_pin_n = 1'b1;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      t_regs();
      t_nop();
      t_irq();
      t_wdt();
      t_master_clear_pin();
      summarize();
   end
endmodule
